// file: rtl/spas_regs.vh
// Purpose: constants for the SRAM page address select block
// Assumes: 8-bit core data address, four 256-byte SRAM pages
// Notes:   access class codes are driven by the core each cycle
// Function
// - Core gives 8-bit offset, 256-byte page
// - Normal page pointer selects one of four
// - Reset clears all pointers and mode bits
// - Normal paging only when flag bit 7 set
// - Mode off: non-stack normal accesses hit page 0
// - Normal accesses use pointer; stack, move excepted
// - Stack, move read and move write paging ignore mode bits
// - Mode bits govern normal and indexed paging
// - Stack uses stack pointer page; SP wraps
// - Move: pointer in current page, third via move pointer
// - Mode table for normal and indexed pages
// - Interrupt clears flags; return restores core's saved copy
`ifndef SPAS_REGS_VH
`define SPAS_REGS_VH
`define SPAS_PAGE_W      2
`define SPAS_OFS_W       8
`define SPAS_PTR_W       3
`define SPAS_FLAG_RST    8'h00
`define SPAS_PTR_RST     3'h0
`define SPAS_SP_RST      8'h00
`define SPAS_MODE_HI     7
`define SPAS_MODE_LO     6
`define SPAS_CLS_NORMAL  3'h0
`define SPAS_CLS_STACK   3'h1
`define SPAS_CLS_INDEX   3'h2
`define SPAS_CLS_MVPTR   3'h3
`define SPAS_CLS_MVREAD  3'h4
`define SPAS_CLS_MVWRITE 3'h5
`define SPAS_MODE_FLAT   2'h0
`define SPAS_MODE_ISTK   2'h1
`define SPAS_MODE_IIDX   2'h2
`define SPAS_MODE_CSTK   2'h3
`endif

// file: rtl/spas_ptr_reg.v
// Purpose: one three-bit page pointer register
// Assumes: written by core with a one-cycle strobe
// Notes:   only the low bits are kept
`timescale 1ns/1ps
`include "spas_regs.vh"
module spas_ptr_reg (
  // Clock and reset
  input  wire                     core_clk,
  input  wire                     resetn,
  // Write port
  input  wire                     wr_en,
  input  wire [7:0]               wr_data,
  // Value
  output reg  [`SPAS_PTR_W-1:0]   ptr_q
);
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= `SPAS_PTR_RST;
    end else if (wr_en) begin
      ptr_q <= wr_data[`SPAS_PTR_W-1:0];
    end
  end
endmodule

// file: rtl/spas_top.v
// Purpose: page select for core SRAM data accesses
// Assumes: core gives access class with each access
// Notes:   address output is combinational from core inputs,
//          so the core sees the page in the cycle it asks;
//          pointer and flag writes share one data bus
`timescale 1ns/1ps
`include "spas_regs.vh"
module spas_top (
  // Clock and reset
  input  wire                     core_clk,
  input  wire                     resetn,

  // Pointer and flag writes
  input  wire [7:0]               wr_data,
  input  wire                     normal_page_pointer_wr,
  input  wire                     stack_page_pointer_wr,
  input  wire                     indexed_page_pointer_wr,
  input  wire                     move_read_page_pointer_wr,
  input  wire                     move_write_page_pointer_wr,
  input  wire                     flag_wr,

  // Interrupt entry and return
  input  wire                     irq_enter,
  input  wire                     irq_return,
  input  wire [7:0]               irq_saved_flag,

  // Core access
  input  wire [2:0]               acc_class,
  input  wire [`SPAS_OFS_W-1:0]   acc_ofs,

  // Stack pointer step
  input  wire                     sp_inc,
  input  wire                     sp_dec,

  // Outputs
  output wire [9:0]               sram_addr,
  output wire [`SPAS_PAGE_W-1:0]  sram_page,
  output wire [7:0]               flag_out,
  output wire [`SPAS_OFS_W-1:0]   sp_out,
  output wire [1:0]               page_mode_bits
);

  // Pointer registers; only bits 1:0 ever reach the address
  wire [`SPAS_PTR_W-1:0]  normal_page_pointer;
  wire [`SPAS_PTR_W-1:0]  stack_page_pointer;
  wire [`SPAS_PTR_W-1:0]  indexed_page_pointer;
  wire [`SPAS_PTR_W-1:0]  move_read_page_pointer;
  wire [`SPAS_PTR_W-1:0]  move_write_page_pointer;

  // Flag register and stack pointer
  reg  [7:0]              flag_q;
  reg  [7:0]              flag_d;
  reg  [`SPAS_OFS_W-1:0]  sp_q;
  reg  [`SPAS_OFS_W-1:0]  sp_d;

  // Access class decode
  wire                    cls_stack;
  wire                    cls_index;
  wire                    cls_move_read;
  wire                    cls_move_write;

  // Page candidates
  reg  [1:0]              idx_src;
  reg  [`SPAS_PTR_W-1:0]  normal_page_d;
  reg  [`SPAS_PTR_W-1:0]  indexed_page_d;
  reg  [`SPAS_PTR_W-1:0]  page_d;

  // Source of the indexed page
  localparam [1:0] IDX_SRC_ZERO  = 2'h0;
  localparam [1:0] IDX_SRC_STACK = 2'h1;
  localparam [1:0] IDX_SRC_INDEX = 2'h2;

  // Writes share wr_data, so the core lands one pointer per cycle
  // Normal page pointer
  spas_ptr_reg u_cur (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (normal_page_pointer_wr),
    .wr_data  (wr_data),
    .ptr_q    (normal_page_pointer)
  );

  // Stack page pointer
  spas_ptr_reg u_stk (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (stack_page_pointer_wr),
    .wr_data  (wr_data),
    .ptr_q    (stack_page_pointer)
  );

  // Indexed page pointer
  spas_ptr_reg u_idx (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (indexed_page_pointer_wr),
    .wr_data  (wr_data),
    .ptr_q    (indexed_page_pointer)
  );

  // Move read page pointer
  spas_ptr_reg u_mvr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (move_read_page_pointer_wr),
    .wr_data  (wr_data),
    .ptr_q    (move_read_page_pointer)
  );

  // Move write page pointer
  spas_ptr_reg u_mvw (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (move_write_page_pointer_wr),
    .wr_data  (wr_data),
    .ptr_q    (move_write_page_pointer)
  );

  // Interrupt entry has priority so an ISR always starts flat
  always @* begin
    flag_d = flag_q;
    if (irq_enter) begin
      flag_d = `SPAS_FLAG_RST;
    end else if (irq_return) begin
      flag_d = irq_saved_flag;
    end else if (flag_wr) begin
      flag_d = wr_data;
    end
  end

  // Saved copy lives outside; the core hands it back on return
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= `SPAS_FLAG_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Eight-bit count wraps inside the stack page by itself; both steps at once hold
  always @* begin
    case ({sp_inc, sp_dec})
      2'h2: begin
        sp_d = sp_q + 8'h01;
      end
      2'h1: begin
        sp_d = sp_q - 8'h01;
      end
      default: begin
        sp_d = sp_q;
      end
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sp_q <= `SPAS_SP_RST;
    end else begin
      sp_q <= sp_d;
    end
  end

  // Mode bits are the top two flag bits
  assign page_mode_bits = {flag_q[`SPAS_MODE_HI], flag_q[`SPAS_MODE_LO]};

  // Classes six and seven fall through to normal paging
  assign cls_stack      = (acc_class == `SPAS_CLS_STACK);
  assign cls_index      = (acc_class == `SPAS_CLS_INDEX);
  assign cls_move_read  = (acc_class == `SPAS_CLS_MVREAD);
  assign cls_move_write = (acc_class == `SPAS_CLS_MVWRITE);

  // Normal and move-pointer accesses; a pointer write alone moves nothing
  always @* begin
    if (page_mode_bits[1]) begin
      normal_page_d = normal_page_pointer;
    end else begin
      normal_page_d = `SPAS_PTR_RST;
    end
  end

  // Both stack modes share one source
  always @* begin
    case (page_mode_bits)
      `SPAS_MODE_FLAT: idx_src = IDX_SRC_ZERO;
      `SPAS_MODE_ISTK: idx_src = IDX_SRC_STACK;
      `SPAS_MODE_IIDX: idx_src = IDX_SRC_INDEX;
      `SPAS_MODE_CSTK: idx_src = IDX_SRC_STACK;
      default:         idx_src = IDX_SRC_ZERO;
    endcase
  end

  // Indexed page from the chosen source
  always @* begin
    case (idx_src)
      IDX_SRC_STACK: indexed_page_d = stack_page_pointer;
      IDX_SRC_INDEX: indexed_page_d = indexed_page_pointer;
      default:       indexed_page_d = `SPAS_PTR_RST;
    endcase
  end

  // Stack and move data accesses never look at the mode bits
  always @* begin
    if (cls_stack) begin
      page_d = stack_page_pointer;
    end else if (cls_move_read) begin
      page_d = move_read_page_pointer;
    end else if (cls_move_write) begin
      page_d = move_write_page_pointer;
    end else if (cls_index) begin
      page_d = indexed_page_d;
    end else begin
      page_d = normal_page_d;
    end
  end

  // Only four pages exist; pointer bit 2 is stored but unused
  assign sram_page = page_d[`SPAS_PAGE_W-1:0];
  assign sram_addr = {sram_page, acc_ofs};
  assign flag_out  = flag_q;
  assign sp_out    = sp_q;
endmodule

// file: verification/spas_properties.sv
// Purpose: port checks for spas_top
// Assumes: single clock, async active-low reset
// Notes:   page table itself is judged by the bench
`timescale 1ns/1ps
module spas_properties (
  // Clock and reset
  input logic        core_clk,
  input logic        resetn,
  // Strobes
  input logic        flag_wr,
  input logic        irq_enter,
  input logic        irq_return,
  input logic        sp_inc,
  input logic        sp_dec,
  // Data and access
  input logic [7:0]  wr_data,
  input logic [7:0]  irq_saved_flag,
  input logic [7:0]  flag_out,
  input logic [7:0]  sp_out,
  input logic [7:0]  acc_ofs,
  input logic [2:0]  acc_class,
  // Results
  input logic [9:0]  sram_addr,
  input logic [1:0]  sram_page,
  input logic [1:0]  page_mode_bits
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_flag_load: assert property (flag_wr && !irq_enter && !irq_return |=> flag_out == $past(wr_data))
    else $error("flag write lost");
  a_irq_clear: assert property (irq_enter |=> flag_out == 8'h00)
    else $error("flags not cleared on entry");
  a_irq_restore: assert property (irq_return && !irq_enter |=> flag_out == $past(irq_saved_flag))
    else $error("flags not restored");
  a_flag_hold: assert property (!flag_wr && !irq_enter && !irq_return |=> $stable(flag_out))
    else $error("flags changed unasked");
  a_mode_bits: assert property (page_mode_bits == flag_out[7:6])
    else $error("mode bits differ from flags");
  a_addr_join: assert property (sram_addr == {sram_page, acc_ofs})
    else $error("address not page over offset");
  a_mode_off: assert property (acc_class == 3'h0 && !flag_out[7] |-> sram_page == 2'h0)
    else $error("normal access left page 0");
  a_sp_wrap: assert property (sp_dec && !sp_inc |=> sp_out == $past(sp_out) - 8'h01)
    else $error("stack pointer step wrong");
  a_sp_up: assert property (sp_inc && !sp_dec |=> sp_out == $past(sp_out) + 8'h01)
    else $error("stack pointer rise wrong");
  cover property (irq_enter);
  cover property (sp_dec && sp_out == 8'h00);
  cover property (acc_class == 3'h2 && page_mode_bits == 2'h3);
endmodule
bind spas_top spas_properties u_chk (.*);

// file: verification/spas_core_model.sv
// Purpose: core side issuing SRAM data accesses
// Assumes: caller changes access on the falling edge
// Notes:   only class and 8-bit offset are modelled
`timescale 1ns/1ps
module spas_core_model (
  // Access to paging logic
  output logic [2:0] acc_class,
  output logic [7:0] acc_ofs
);
  task access(input logic [2:0] c, input logic [7:0] o);
    acc_class = c;
    acc_ofs   = o;
  endtask
endmodule

// file: verification/spas_top_tb_top.sv
// Purpose: directed bench for spas_top
// Assumes: inputs change on the falling edge
// Notes:   pointers chosen so normal, stack and indexed sources give distinct pages; move read shares page 1, move write page 3
`timescale 1ns/1ps
module spas_top_tb_top;
  logic       core_clk = 0, resetn = 0;
  logic [9:0] st = 0;
  logic [7:0] wr_data = 0, irq_saved_flag = 0;
  wire  [2:0] acc_class;
  wire  [7:0] acc_ofs, flag_out, sp_out;
  wire  [9:0] sram_addr;
  wire  [1:0] sram_page, page_mode_bits;
  int         err_total = 0, tests_run = 0;
  spas_core_model m (.acc_class(acc_class), .acc_ofs(acc_ofs));
  spas_top uut (.core_clk(core_clk), .resetn(resetn), .wr_data(wr_data), .normal_page_pointer_wr(st[0]),
    .stack_page_pointer_wr(st[1]), .indexed_page_pointer_wr(st[2]), .move_read_page_pointer_wr(st[3]),
    .move_write_page_pointer_wr(st[4]), .flag_wr(st[5]), .irq_enter(st[6]), .irq_return(st[7]),
    .irq_saved_flag(irq_saved_flag), .acc_class(acc_class), .acc_ofs(acc_ofs), .sp_inc(st[8]), .sp_dec(st[9]),
    .sram_addr(sram_addr), .sram_page(sram_page), .flag_out(flag_out), .sp_out(sp_out),
    .page_mode_bits(page_mode_bits));
  initial forever #4 core_clk = ~core_clk;
  task chk(input logic [9:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One strobe per call, held across exactly one rising edge
  task wr(input int k, input logic [7:0] d);
    @(negedge core_clk);
    st = 10'h001 << k;
    wr_data = d;
    @(negedge core_clk);
    st = 10'h000;
  endtask
  task acc(input logic [2:0] c, input logic [1:0] p);
    @(negedge core_clk);
    m.access(c, 8'h5A);
    #1 chk(sram_addr, {p, 8'h5A});
  endtask
  task complete_run;
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    complete_run;
  end
  initial begin
    m.access(3'h2, 8'h5A);
    repeat (12) @(negedge core_clk);
    chk(sram_addr, 10'h05A);
    acc(1, 2'h0);
    acc(4, 2'h0);
    acc(5, 2'h0);
    @(negedge core_clk);
    resetn = 1;
    chk(flag_out, 10'h000);
    chk(sp_out, 10'h000);
    wr(0, 8'h06);
    wr(1, 8'h03);
    wr(2, 8'h01);
    wr(3, 8'h01);
    wr(4, 8'h07);
    irq_saved_flag = 8'hC0;
    acc(0, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr(5, {i[1:0], 6'h00});
      chk(page_mode_bits, i[1:0]);
      acc(0, i[1] ? 2'h2 : 2'h0);
      acc(2, i == 0 ? 2'h0 : i == 2 ? 2'h1 : 2'h3);
      acc(1, 2'h3);
      acc(4, 2'h1);
      acc(5, 2'h3);
      acc(3, i[1] ? 2'h2 : 2'h0);
    end
    wr(6, 8'h00);
    acc(0, 2'h0);
    acc(1, 2'h3);
    wr(7, 8'h00);
    acc(0, 2'h2);
    wr(9, 8'h00);
    chk(sp_out, 10'h0FF);
    wr(8, 8'h00);
    chk(sp_out, 10'h000);
    wr(0, 8'h05);
    acc(0, 2'h1);
    complete_run;
  end
endmodule
